// *** shared/t1prf_pkg.sv ***
// t1prf_pkg: constants and types of the t1 performance report framer
// Functional notes
// - address by role, tei octet, control 03
// - opening flag, eleven octets, fcs, closing flag
// - every octet sent bit 1 first
// - octets 5,6 carry latest second
// - three older seconds follow, newest first
// - one crc band flag per nonzero count, none for zero
// - severe framing flag forces sync error zero
// - sync bit error flag only without severe
// - violation, slip, loopback flags per second
// - both study bits sent as zero
// - reserved bit zero by default
// - modulo 4 report counter per second
`default_nettype none

package t1prf_pkg;

  // ----------------------------------------
  // frame octets
  // ----------------------------------------
  localparam logic [7:0] FLAG_OCTET = 8'h7e;
  localparam logic [7:0] ADDR_CI = 8'h38;
  localparam logic [7:0] ADDR_CARRIER = 8'h3a;
  localparam logic [7:0] TEI_OCTET = 8'h01;
  localparam logic [7:0] CTRL_UI = 8'h03;
  localparam int BODY_OCTETS = 11;
  localparam int HIST_SECONDS = 4;
  localparam logic [2:0] STUFF_RUN = 3'h5;

  // ----------------------------------------
  // crc16 (reflected ccitt)
  // ----------------------------------------
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY_REFL = 16'h8408;

  // ----------------------------------------
  // crc error count bands
  // ----------------------------------------
  localparam int CRC_CNT_W = 9;
  localparam logic [8:0] BAND_ONE = 9'h001;
  localparam logic [8:0] BAND_FIVE = 9'h005;
  localparam logic [8:0] BAND_TEN = 9'h00a;
  localparam logic [8:0] BAND_HUNDRED = 9'h064;
  localparam logic [8:0] BAND_319 = 9'h13f;
  localparam logic [8:0] BAND_SAT = 9'h140;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int REPORT_PERIOD_MS = 1000;
  localparam int REPORT_CYCLES = REPORT_PERIOD_MS * 1000 * CLK_MHZ;

  // ----------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_HISTORY = 8'h08;
  localparam logic [7:0] REG_REPORTS = 8'h0c;
  localparam logic [7:0] REG_CRC_NOW = 8'h10;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CARRIER_BIT = 1;
  localparam int CTRL_RSVD_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    SEL_CTRL,
    SEL_STATUS,
    SEL_HISTORY,
    SEL_REPORTS,
    SEL_CRC_NOW,
    SEL_NONE
  } t1prf_sel_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPEN = 3'b001,
    ST_BODY = 3'b011,
    ST_FCS = 3'b010,
    ST_CLOSE = 3'b110
  } t1prf_state_t;

  // one-cycle event strobes from the line side, plus loopback level
  typedef struct packed {
    logic crc_err;
    logic sev_framing;
    logic sync_bit_err;
    logic line_code_viol;
    logic frame_slip;
    logic loopback;
  } t1prf_events_t;

  // one second of history as sent on the link
  typedef struct packed {
    logic [7:0] odd_octet;
    logic [7:0] even_octet;
  } t1prf_second_t;

endpackage : t1prf_pkg

`default_nettype wire

// *** hdl/t1prf_band_encode.sv ***
// t1prf_band_encode: one second of counts into its two report octets
`default_nettype none

module t1prf_band_encode (
  // counts of the second
  input wire logic [8:0] crc_cnt_i,
  input wire logic sev_i,
  input wire logic sync_err_i,
  input wire logic viol_i,
  input wire logic slip_i,
  input wire logic loop_i,
  input wire logic rsvd_i,
  input wire logic [1:0] seq_i,
  // encoded pair
  output t1prf_pkg::t1prf_second_t sec_o
);

  logic crc_one_error_flag, crc_two_to_five_flag, crc_six_to_ten_flag;
  logic crc_eleven_to_hundred_flag, crc_upto_319_flag, crc_320_plus_flag;
  logic frame_sync_bit_error_flag;
  logic sync_study_bit_a, sync_study_bit_b;

  assign crc_one_error_flag = (crc_cnt_i == t1prf_pkg::BAND_ONE);
  assign crc_two_to_five_flag = (crc_cnt_i > t1prf_pkg::BAND_ONE) && (crc_cnt_i <= t1prf_pkg::BAND_FIVE);
  assign crc_six_to_ten_flag = (crc_cnt_i > t1prf_pkg::BAND_FIVE) && (crc_cnt_i <= t1prf_pkg::BAND_TEN);
  assign crc_eleven_to_hundred_flag = (crc_cnt_i > t1prf_pkg::BAND_TEN) && (crc_cnt_i <= t1prf_pkg::BAND_HUNDRED);
  assign crc_upto_319_flag = (crc_cnt_i > t1prf_pkg::BAND_HUNDRED) && (crc_cnt_i <= t1prf_pkg::BAND_319);
  assign crc_320_plus_flag = (crc_cnt_i >= t1prf_pkg::BAND_SAT);

  assign frame_sync_bit_error_flag = sync_err_i && !sev_i;

  assign sync_study_bit_a = 1'b0;
  assign sync_study_bit_b = 1'b0;

  // bit layout, bit 8 at msb
  assign sec_o.odd_octet = {crc_six_to_ten_flag, viol_i, crc_eleven_to_hundred_flag, sync_study_bit_a,
                            sync_study_bit_b, crc_upto_319_flag, slip_i, crc_320_plus_flag};
  assign sec_o.even_octet = {frame_sync_bit_error_flag, sev_i, loop_i, crc_one_error_flag,
                             rsvd_i, crc_two_to_five_flag, seq_i};

endmodule : t1prf_band_encode

`default_nettype wire

// *** hdl/t1prf_crc16.sv ***
// t1prf_crc16: bit-serial reflected ccitt crc16 for the frame check sequence
`default_nettype none

module t1prf_crc16 (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // bit stream
  input wire logic clear_i,
  input wire logic shift_i,
  input wire logic bit_i,
  // remainder
  output logic [15:0] crc_o
);

  logic [15:0] crc_q;
  logic fb;

  assign fb = crc_q[0] ^ bit_i;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      crc_q <= t1prf_pkg::CRC_INIT;
    end else if (clear_i) begin
      crc_q <= t1prf_pkg::CRC_INIT;
    end else if (shift_i) begin
      crc_q <= (crc_q >> 1) ^ (fb ? t1prf_pkg::CRC_POLY_REFL : 16'h0000);
    end
  end

  assign crc_o = crc_q;

endmodule : t1prf_crc16

`default_nettype wire

// *** hdl/t1prf_framer.sv ***
// t1prf_framer: one-second performance report builder with axi4-lite registers
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`default_nettype none

module t1prf_framer #(
  parameter int REPORT_CYCLES = t1prf_pkg::REPORT_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // axi4-lite write address and data
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  // axi4-lite write response
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  // axi4-lite read
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [7:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  // line events
  input wire t1prf_pkg::t1prf_events_t events_i,
  // facility data link
  input wire logic dl_bit_req_i,
  output logic dl_data_o,
  output logic dl_frame_o
);

  // ----------------------------------------
  // decoding
  // ----------------------------------------
  function automatic t1prf_pkg::t1prf_sel_t decode(input logic [7:0] addr);
    unique case (addr)
      t1prf_pkg::REG_CTRL: decode = t1prf_pkg::SEL_CTRL;
      t1prf_pkg::REG_STATUS: decode = t1prf_pkg::SEL_STATUS;
      t1prf_pkg::REG_HISTORY: decode = t1prf_pkg::SEL_HISTORY;
      t1prf_pkg::REG_REPORTS: decode = t1prf_pkg::SEL_REPORTS;
      t1prf_pkg::REG_CRC_NOW: decode = t1prf_pkg::SEL_CRC_NOW;
      default: decode = t1prf_pkg::SEL_NONE;
    endcase
  endfunction : decode

  // ----------------------------------------
  // axi4-lite write side
  // ----------------------------------------
  logic aw_held_q, w_held_q, bvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q;
  logic aw_have, w_have, wr_fire;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [2:0] ctrl_q;

  assign s_axi_awready_o = !aw_held_q && !bvalid_q;
  assign s_axi_wready_o = !w_held_q && !bvalid_q;
  assign aw_have = aw_held_q || (s_axi_awvalid_i && s_axi_awready_o);
  assign w_have = w_held_q || (s_axi_wvalid_i && s_axi_wready_o);
  assign wr_fire = aw_have && w_have;
  assign wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr_i;
  assign wr_data = w_held_q ? wdata_q : s_axi_wdata_i;
  assign wr_strb = w_held_q ? wstrb_q : s_axi_wstrb_i;

  // either channel may arrive first; hold it until its partner shows up
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        awaddr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      aw_held_q <= aw_have && !wr_fire;
      w_held_q <= w_have && !wr_fire;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= t1prf_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= (decode(wr_addr) == t1prf_pkg::SEL_NONE) ? t1prf_pkg::RESP_DECERR : t1prf_pkg::RESP_OKAY;
    end else if (s_axi_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;

  // only the control register is writable; status words ignore writes
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q <= t1prf_pkg::CTRL_RESET;
    end else if (wr_fire && decode(wr_addr) == t1prf_pkg::SEL_CTRL && wr_strb[0]) begin
      ctrl_q <= wr_data[2:0];
    end
  end

  // ----------------------------------------
  // one-second accumulation
  // ----------------------------------------
  logic [31:0] tick_cnt_q;
  logic tick;
  logic [8:0] crc_cnt_q;
  logic sev_q, sync_q, viol_q, slip_q, loop_q;
  logic [1:0] seq_q;
  logic [31:0] reports_q;
  t1prf_pkg::t1prf_second_t now_sec;
  t1prf_pkg::t1prf_second_t hist_q [t1prf_pkg::HIST_SECONDS];

  assign tick = (tick_cnt_q == 32'(REPORT_CYCLES - 1));

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_cnt_q <= 32'h0000_0000;
    end else if (tick) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  // an event in the closing cycle opens the new second rather than being lost
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      crc_cnt_q <= 9'h000;
    end else if (tick) begin
      crc_cnt_q <= {8'h00, events_i.crc_err};
    end else if (events_i.crc_err && crc_cnt_q != t1prf_pkg::BAND_SAT) begin
      crc_cnt_q <= crc_cnt_q + 9'h001;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sev_q <= 1'b0;
      sync_q <= 1'b0;
      viol_q <= 1'b0;
      slip_q <= 1'b0;
      loop_q <= 1'b0;
    end else begin
      sev_q <= events_i.sev_framing || (sev_q && !tick);
      sync_q <= events_i.sync_bit_err || (sync_q && !tick);
      viol_q <= events_i.line_code_viol || (viol_q && !tick);
      slip_q <= events_i.frame_slip || (slip_q && !tick);
      loop_q <= events_i.loopback || (loop_q && !tick);
    end
  end

  t1prf_band_encode u_encode (
    .crc_cnt_i(crc_cnt_q),
    .sev_i(sev_q),
    .sync_err_i(sync_q),
    .viol_i(viol_q),
    .slip_i(slip_q),
    .loop_i(loop_q),
    .rsvd_i(ctrl_q[t1prf_pkg::CTRL_RSVD_BIT]),
    .seq_i(seq_q),
    .sec_o(now_sec)
  );

  // modulo 4 counter; oldest second drops out
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      seq_q <= 2'h0;
      reports_q <= 32'h0000_0000;
      for (int i = 0; i < t1prf_pkg::HIST_SECONDS; i++) begin
        hist_q[i] <= '0;
      end
    end else if (tick) begin
      seq_q <= seq_q + 2'h1;
      reports_q <= reports_q + 32'h0000_0001;
      hist_q[0] <= now_sec;
      for (int i = 1; i < t1prf_pkg::HIST_SECONDS; i++) begin
        hist_q[i] <= hist_q[i-1];
      end
    end
  end

  // ----------------------------------------
  // frame snapshot and serialiser
  // ----------------------------------------
  t1prf_pkg::t1prf_state_t state_q;
  logic [7:0] body_q [t1prf_pkg::BODY_OCTETS];
  logic pend_q, load;
  logic [3:0] oct_q;
  logic [2:0] bit_q;
  logic [2:0] ones_q;
  logic [15:0] crc_val;
  logic stuff, cur_bit, last_bit, crc_shift, crc_clear;

  // a zero follows five ones between flags
  assign stuff = (state_q == t1prf_pkg::ST_BODY || state_q == t1prf_pkg::ST_FCS ||
                  state_q == t1prf_pkg::ST_CLOSE) && ones_q == t1prf_pkg::STUFF_RUN;
  assign last_bit = (bit_q == 3'h7);

  // bit 1 of each octet leads
  always_comb begin
    unique case (state_q)
      t1prf_pkg::ST_BODY: cur_bit = body_q[oct_q][bit_q];
      t1prf_pkg::ST_FCS: cur_bit = ~crc_val[{oct_q[0], bit_q}];
      default: cur_bit = t1prf_pkg::FLAG_OCTET[bit_q];
    endcase
  end

  assign crc_shift = dl_bit_req_i && state_q == t1prf_pkg::ST_BODY && !stuff;
  assign crc_clear = dl_bit_req_i && state_q == t1prf_pkg::ST_OPEN;

  t1prf_crc16 u_crc (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .clear_i(crc_clear),
    .shift_i(crc_shift),
    .bit_i(cur_bit),
    .crc_o(crc_val)
  );

  // a report that comes due while one is on the wire waits for it to end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_q <= 1'b0;
    end else if (tick && ctrl_q[t1prf_pkg::CTRL_ENABLE_BIT]) begin
      pend_q <= 1'b1;
    end else if (load) begin
      pend_q <= 1'b0;
    end
  end

  // snapshot: header then newest second first
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < t1prf_pkg::BODY_OCTETS; i++) begin
        body_q[i] <= 8'h00;
      end
    end else if (load) begin
      body_q[0] <= ctrl_q[t1prf_pkg::CTRL_CARRIER_BIT] ? t1prf_pkg::ADDR_CARRIER : t1prf_pkg::ADDR_CI;
      body_q[1] <= t1prf_pkg::TEI_OCTET;
      body_q[2] <= t1prf_pkg::CTRL_UI;
      for (int i = 0; i < t1prf_pkg::HIST_SECONDS; i++) begin
        body_q[3 + 2*i] <= hist_q[i].odd_octet;
        body_q[4 + 2*i] <= hist_q[i].even_octet;
      end
    end
  end

  assign load = dl_bit_req_i && state_q == t1prf_pkg::ST_IDLE && last_bit && pend_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= t1prf_pkg::ST_IDLE;
      oct_q <= 4'h0;
      bit_q <= 3'h0;
    end else if (dl_bit_req_i && !stuff) begin
      bit_q <= bit_q + 3'h1;
      unique case (state_q)
        t1prf_pkg::ST_IDLE: begin
          if (load) begin
            state_q <= t1prf_pkg::ST_OPEN;
          end
        end
        t1prf_pkg::ST_OPEN: begin
          if (last_bit) begin
            state_q <= t1prf_pkg::ST_BODY;
            oct_q <= 4'h0;
          end
        end
        t1prf_pkg::ST_BODY: begin
          if (last_bit) begin
            oct_q <= oct_q + 4'h1;
            if (oct_q == 4'(t1prf_pkg::BODY_OCTETS - 1)) begin
              state_q <= t1prf_pkg::ST_FCS;
              oct_q <= 4'h0;
            end
          end
        end
        t1prf_pkg::ST_FCS: begin
          if (last_bit) begin
            oct_q <= oct_q + 4'h1;
            if (oct_q[0]) begin
              state_q <= t1prf_pkg::ST_CLOSE;
            end
          end
        end
        t1prf_pkg::ST_CLOSE: begin
          if (last_bit) begin
            state_q <= t1prf_pkg::ST_IDLE;
          end
        end
        default: state_q <= t1prf_pkg::ST_IDLE;
      endcase
    end
  end

  // run of ones between the flags
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ones_q <= 3'h0;
    end else if (dl_bit_req_i) begin
      if (stuff || !(state_q == t1prf_pkg::ST_BODY || state_q == t1prf_pkg::ST_FCS)) begin
        ones_q <= 3'h0;
      end else begin
        ones_q <= cur_bit ? ones_q + 3'h1 : 3'h0;
      end
    end
  end

  // line idles on flags while enabled, marks otherwise
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dl_data_o <= 1'b1;
      dl_frame_o <= 1'b0;
    end else if (dl_bit_req_i) begin
      if (stuff) begin
        dl_data_o <= 1'b0;
      end else if (state_q == t1prf_pkg::ST_IDLE && !ctrl_q[t1prf_pkg::CTRL_ENABLE_BIT]) begin
        dl_data_o <= 1'b1;
      end else begin
        dl_data_o <= cur_bit;
      end
      dl_frame_o <= (state_q != t1prf_pkg::ST_IDLE);
    end
  end

  // ----------------------------------------
  // axi4-lite read side
  // ----------------------------------------
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] rd_word;

  assign s_axi_arready_o = !rvalid_q;

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (decode(s_axi_araddr_i))
      t1prf_pkg::SEL_CTRL: rd_word = {29'h0, ctrl_q};
      t1prf_pkg::SEL_STATUS: rd_word = {25'h0, pend_q, state_q, state_q != t1prf_pkg::ST_IDLE, seq_q};
      t1prf_pkg::SEL_HISTORY: rd_word = {hist_q[1], hist_q[0]};
      t1prf_pkg::SEL_REPORTS: rd_word = reports_q;
      t1prf_pkg::SEL_CRC_NOW: rd_word = {23'h0, crc_cnt_q};
      t1prf_pkg::SEL_NONE: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= t1prf_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= (decode(s_axi_araddr_i) == t1prf_pkg::SEL_NONE) ? t1prf_pkg::RESP_DECERR
                                                                 : t1prf_pkg::RESP_OKAY;
    end else if (s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;

endmodule : t1prf_framer

`default_nettype wire

// *** tb/t1prf_framer_props.sv ***
// t1prf_framer_props: port checks on the report framer
`default_nettype none

module t1prf_framer_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // register read
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_rvalid_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  // data link
  input wire logic dl_bit_req_i,
  input wire logic dl_data_o,
  input wire logic dl_frame_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ----
  // slot tracking: a line bit is seen one edge after its request
  // ----
  logic rq_q;
  logic in_q;
  logic [7:0] sh_q;
  logic [7:0] fcnt_q;
  logic [2:0] ones_q;
  logic [7:0] oct;
  logic slot;
  assign oct = {dl_data_o, sh_q[7:1]};
  assign slot = rq_q && dl_frame_o;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rq_q <= 1'b0;
      in_q <= 1'b0;
      sh_q <= 8'h00;
      fcnt_q <= 8'h00;
      ones_q <= 3'h0;
    end else begin
      rq_q <= dl_bit_req_i;
      if (rq_q) begin
        sh_q <= oct;
        in_q <= dl_frame_o;
        fcnt_q <= dl_frame_o ? fcnt_q + 8'h01 : 8'h00;
        ones_q <= (dl_frame_o && dl_data_o) ? ones_q + 3'h1 : 3'h0;
      end
    end
  end
  chk_open_flag: assert property (slot && fcnt_q == 8'h07 |-> oct == 8'h7e)
    else $error("opening flag wrong");
  chk_addr_role: assert property (slot && fcnt_q == 8'h0f |-> (oct | 8'h02) == 8'h3a)
    else $error("address octet wrong");
  chk_tei_octet: assert property (slot && fcnt_q == 8'h17 |-> oct == 8'h01)
    else $error("tei octet wrong");
  chk_ctrl_octet: assert property (slot && fcnt_q == 8'h1f |-> oct == 8'h03)
    else $error("control octet wrong");
  chk_study_zero: assert property (slot && fcnt_q == 8'h27 |-> oct[4:3] == 2'h0)
    else $error("study bits set");
  chk_stuff_run: assert property (slot && ones_q == 3'h6 |-> !dl_data_o)
    else $error("seven ones in frame");
  chk_close_flag: assert property (rq_q && !dl_frame_o && in_q |-> sh_q == 8'h7e)
    else $error("closing flag wrong");
  chk_frame_len: assert property (rq_q && !dl_frame_o && in_q |-> fcnt_q >= 8'h78 && fcnt_q <= 8'h8e)
    else $error("frame length wrong");
  chk_line_hold: assert property (!dl_bit_req_i |=> $stable(dl_data_o) && $stable(dl_frame_o))
    else $error("line moved without request");
  chk_rd_decerr: assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i > 8'h10
    |=> s_axi_rvalid_o && s_axi_rresp_o == 2'h3 && s_axi_rdata_o == 32'h0)
    else $error("unmapped read answered wrongly");
  cov_frame_end: cover property (rq_q && !dl_frame_o && in_q);
  cov_decerr: cover property (s_axi_rvalid_o && s_axi_rresp_o == 2'h3);
  cov_stuffed: cover property (slot && ones_q == 3'h5 && !dl_data_o);
endmodule : t1prf_framer_props

bind t1prf_framer t1prf_framer_props t1prf_framer_props_i (.*);

`default_nettype wire

// *** tb/t1prf_link_rx.sv ***
// t1prf_link_rx: far-end link receiver that asks for bits and unstuffs frames
`default_nettype none

module t1prf_link_rx (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // link
  input wire logic slow_i,
  input wire logic data_i,
  input wire logic frame_i,
  output logic req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] gap_q;
  logic raw[$];
  logic [7:0] oct[$];
  int nfr = 0;
  int rawn = 0;
  // slow mode asks for one bit every fourth clock
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gap_q <= 2'h0;
      req_o <= 1'b0;
    end else begin
      gap_q <= gap_q + 2'h1;
      req_o <= !slow_i || gap_q == 2'h3;
    end
  end
  always @(posedge clk_i) begin
    if (req_o) begin
      #1;
      if (frame_i) begin
        raw.push_back(data_i);
      end else if (raw.size() > 0) begin
        unstuff();
      end
    end
  end
  task automatic unstuff;
    int ones;
    logic [7:0] v;
    ones = 0;
    v = 8'h00;
    oct = {};
    rawn = raw.size();
    // flags dropped; a zero after five ones is not data
    for (int i = 8; i < rawn - 8; i++) begin
      if (ones == 5 && !raw[i]) begin
        ones = 0;
        continue;
      end
      v = {raw[i], v[7:1]};
      ones = raw[i] ? ones + 1 : 0;
      oct.push_back(v);
    end
    for (int k = 0; k < oct.size() / 8; k++) begin
      oct[k] = oct[k * 8 + 7];
    end
    oct = oct[0:oct.size() / 8 - 1];
    raw = {};
    nfr++;
  endtask : unstuff
endmodule : t1prf_link_rx

`default_nettype wire

// *** tb/testbench.sv ***
// testbench: ten report seconds compared with a bench model
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NS = 10;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic bready = 1'b1;
  logic rready = 1'b1;
  logic slow = 1'b0;
  logic [3:0] wstrb = 4'hf;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  t1prf_pkg::t1prf_events_t ev = '0;
  logic awready, wready, bvalid, arready, rvalid, req, dld, dlf;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] od[-3:NS] = '{default: 8'h00};
  logic [7:0] evn[-3:NS] = '{default: 8'h00};
  logic [7:0] ad[NS];
  int crcn[NS] = '{0, 1, 2, 5, 6, 11, 100, 101, 319, 330};
  int seed = 85839;
  int fails = 0;
  int checked = 0;

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  t1prf_framer #(.REPORT_CYCLES(2000)) t1prf_framer_i (
    .clk_i(clk_i), .rstn_i(rstn_i),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_araddr_i(araddr),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .events_i(ev), .dl_bit_req_i(req), .dl_data_o(dld), .dl_frame_o(dlf)
  );
  t1prf_link_rx t1prf_link_rx_i (.clk_i(clk_i), .rstn_i(rstn_i), .slow_i(slow), .data_i(dld),
    .frame_i(dlf), .req_o(req));

  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  task automatic tmo;
    $display("unexpected wait: expected answer seen none");
    fails++;
    finish_test();
  endtask : tmo

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    int t;
    t = 0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk_i);
      t++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && t < 50);
    if (t >= 50) tmo();
    chk("bresp", er, bresp);
  endtask : wr

  task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] er, string n);
    int t;
    t = 0;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk_i);
      t++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && t < 50);
    if (t >= 50) tmo();
    chk(n, e, rdata);
    chk("rresp", er, rresp);
  endtask : rd

  // one second of events plus the bench's encoding of it
  task automatic inject(int s);
    int p[5];
    int n;
    logic [31:0] c;
    logic sf;
    n = crcn[s];
    c = ($random(seed) & 32'h6) | 32'h1;
    foreach (p[j]) p[j] = $random(seed) & 511;
    if (s % 2 == 1) p[0] = 999;
    wr(8'h00, c, 2'h0);
    for (int i = 0; i < 400; i++) begin
      @(posedge clk_i);
      ev <= {i < n, i == p[0], i == p[1], i == p[2], i == p[3], i == p[4]};
    end
    @(posedge clk_i);
    ev <= '0;
    sf = p[0] < 400;
    od[s] = {n > 5 && n <= 10, p[2] < 400, n > 10 && n <= 100, 2'h0, n > 100 && n <= 319, p[3] < 400, n >= 320};
    evn[s] = {p[1] < 400 && !sf, sf, p[4] < 400, n == 1, c[2], n > 1 && n <= 5, 2'(s)};
    ad[s] = c[1] ? 8'h3a : 8'h38;
    rd(8'h10, n > 320 ? 320 : n, 2'h0, "crc count");
  endtask : inject

  task automatic check(int s);
    logic [7:0] e[$];
    logic [15:0] crc;
    int ones;
    int nb;
    crc = 16'hffff;
    ones = 0;
    nb = 16;
    e = {ad[s], 8'h01, 8'h03};
    for (int k = 0; k < 4; k++) begin
      e.push_back(od[s - k]);
      e.push_back(evn[s - k]);
    end
    for (int k = 0; k < 13; k++) begin
      if (k == 11) begin
        e.push_back(~crc[7:0]);
        e.push_back(~crc[15:8]);
      end
      for (int b = 0; b < 8; b++) begin
        if (k < 11) crc = (crc >> 1) ^ ((crc[0] ^ e[k][b]) ? 16'h8408 : 16'h0000);
        nb++;
        ones = e[k][b] ? ones + 1 : 0;
        if (ones == 5) begin
          nb++;
          ones = 0;
        end
      end
    end
    chk("raw bits", nb, t1prf_link_rx_i.rawn);
    chk("octets", 13, t1prf_link_rx_i.oct.size());
    foreach (e[k]) chk("octet", e[k], t1prf_link_rx_i.oct[k]);
    rd(8'h08, {od[s - 1], evn[s - 1], od[s], evn[s]}, 2'h0, "history");
    rd(8'h0c, s + 1, 2'h0, "reports");
  endtask : check

  initial begin
    int t;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(8'h00, 32'h0, 2'h0, "ctrl reset");
    rd(8'h04, 32'h0, 2'h0, "status reset");
    rd(8'h14, 32'h0, 2'h3, "unmapped read");
    wr(8'h20, 32'h7, 2'h3);
    wr(8'h0c, $random(seed), 2'h0);
    rd(8'h00, 32'h0, 2'h0, "ctrl kept");
    chk("idle line", 2'h2, {dld, dlf});
    inject(0);
    for (int s = 0; s < NS; s++) begin
      t = 0;
      while (dlf !== 1'b1 && t < 5000) begin
        @(posedge clk_i);
        t++;
      end
      if (t >= 5000) tmo();
      slow <= ~slow;
      if (s < NS - 1) inject(s + 1);
      t = 0;
      while (t1prf_link_rx_i.nfr <= s && t < 5000) begin
        @(posedge clk_i);
        t++;
      end
      if (t >= 5000) tmo();
      check(s);
      $display("second %0d report checked", s);
    end
    finish_test();
  end
endmodule : testbench

`default_nettype wire
